// File: core/netadapt_pkg.sv
// Purpose: Shared constants for the serial network adapter configuration core
// Assumes: 40 MHz system clock
// Notes:   Strap encodings, rate table, address defaults and timing counts
package netadapt_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ         = 40_000_000; // System clock rate
	localparam int unsigned BLINK_MS       = 250;        // Service blink half period
	localparam int unsigned BLINK_CYC      = CLK_HZ / 1000 * BLINK_MS;
	localparam int unsigned DEBOUNCE_MS    = 10;         // Push-button settle time
	localparam int unsigned DEBOUNCE_CYC   = CLK_HZ / 1000 * DEBOUNCE_MS;

	// ----------------------------------------
	// Strap encodings (value of a strap after synchronising)
	// ----------------------------------------
	localparam logic ROLE_DCE      = 1'b0; // Default role
	localparam logic ROLE_DTE      = 1'b1;
	localparam logic PROTO_ACK     = 1'b0; // Acknowledged handshake, default
	localparam logic PROTO_BUF     = 1'b1; // Buffered back-to-back
	localparam logic HOST_LOCAL    = 1'b0; // Default
	localparam logic HOST_REMOTE   = 1'b1;
	localparam logic NET_DISABLED  = 1'b0; // Default: hold-off after reset
	localparam logic NET_ENABLED   = 1'b1;
	localparam logic WIRE_3        = 1'b0; // Default: TXD, RXD, ground
	localparam logic WIRE_8        = 1'b1; // Full modem handshake
	localparam logic AUTO_OFF      = 1'b0; // Default
	localparam logic AUTO_ON       = 1'b1;
	localparam logic [2:0] RATE_SEL_DEFAULT = 3'h3; // 9600 bit/s

	// ----------------------------------------
	// Rate table, bit/s
	// ----------------------------------------
	localparam int unsigned RATE_14400  = 14400;
	localparam int unsigned RATE_1200   = 1200;
	localparam int unsigned RATE_2400   = 2400;
	localparam int unsigned RATE_9600   = 9600;
	localparam int unsigned RATE_19200  = 19200;
	localparam int unsigned RATE_38400  = 38400;
	localparam int unsigned RATE_57600  = 57600;
	localparam int unsigned RATE_115200 = 115200;
	localparam int unsigned DIV_W       = 16; // Width of bit period divisor

	// ----------------------------------------
	// Network address defaults
	// ----------------------------------------
	localparam logic [6:0] NODE_DEFAULT   = 7'h7f; // Node 127
	localparam logic [7:0] SUBNET_DEFAULT = 8'h01; // Subnet 1

	// ----------------------------------------
	// Service indicator states
	// ----------------------------------------
	typedef enum logic [1:0] {
		LED_BLINK = 2'b00, // Unconfigured
		LED_OFF   = 2'b01, // Configured
		LED_ON    = 2'b11  // Hardware failure
	} led_mode_t;

endpackage

// File: core/netadapt_cfg.sv
// Purpose: Strap capture, host pin roles, rate select, hold-off, service
//          message, address store and service indicator of the adapter
// Assumes: Straps and button are asynchronous pins; address writes and
//          nonvolatile handshake are on clk
// Notes:   A two-entry buffer carries service messages to the network side
`timescale 1ns/1ps
`default_nettype none

module netadapt_cfg
	import netadapt_pkg::*;
#(
	parameter int unsigned BLINK_CYCLES    = BLINK_CYC,   // Blink half period
	parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC // Button settle time
) (
	input  wire logic              clk,              // System clock
	input  wire logic              rst_n,            // Sync reset, active low
	input  wire logic              role_strap_group, // 1 = DTE
	input  wire logic              link_protocol_strap, // 1 = buffered
	input  wire logic              host_location_strap, // 1 = remote
	input  wire logic              network_enable_strap, // 1 = enabled
	input  wire logic              wiring_width_strap, // 1 = 8-wire
	input  wire logic              auto_rate_strap,  // 1 = autobaud
	input  wire logic              rate_select_bit2, // Rate bit, MSB
	input  wire logic              rate_select_bit1, // Rate bit
	input  wire logic              rate_select_bit0, // Rate bit, LSB
	input  wire logic              service_button_n, // Pushed when low
	input  wire logic              host_pin2_i,      // Pin 2 level in
	input  wire logic              host_pin3_i,      // Pin 3 level in
	input  wire logic [4:0]        host_hs_i,        // DCD,DSR,CTS,RI,DTR/RTS ins
	input  wire logic              core_txd,         // Serial data from core
	input  wire logic              core_rts,         // Core handshake out
	input  wire logic              auto_rate_valid,  // Detector locked
	input  wire logic [DIV_W-1:0]  auto_rate_div,    // Detected bit divisor
	input  wire logic              holdoff_release_message, // Release pulse
	input  wire logic              addr_wr,          // Address write pulse
	input  wire logic [6:0]        addr_node_in,     // New node number
	input  wire logic [7:0]        addr_subnet_in,   // New subnet number
	input  wire logic              cfg_done,         // Node configured pulse
	input  wire logic              hw_fault,         // Hardware failure level
	input  wire logic              nv_ready,         // Nonvolatile store ready
	input  wire logic              svc_ready,        // Network takes message
	output logic                   host_pin2_o,      // Pin 2 drive level
	output logic                   host_pin2_oe,     // Pin 2 driven
	output logic                   host_pin3_o,      // Pin 3 drive level
	output logic                   host_pin3_oe,     // Pin 3 driven
	output logic [5:0]             host_hs_o,        // DCD,DSR,CTS,RI,DTR,RTS
	output logic [5:0]             host_hs_oe,       // Enable per handshake pin
	output logic                   core_rxd,         // Serial data to core
	output logic                   proto_buffered,   // Buffered protocol
	output logic                   host_remote,      // Remote host mode
	output logic                   wire8,            // 8-wire mode
	output logic                   auto_rate_on,     // Autobaud active
	output logic [DIV_W-1:0]       bit_div,          // Clocks per bit
	output logic                   net_enable,       // Network traffic allowed
	output logic                   svc_valid,        // Service message pending
	output logic [6:0]             node_addr,        // Active node number
	output logic [7:0]             subnet_addr,      // Active subnet number
	output logic                   nv_wr,            // Store address pulse
	output logic [14:0]            nv_data,          // Node and subnet to store
	output logic                   service_led       // Service indicator
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (BLINK_CYCLES < 2 || DEBOUNCE_CYCLES < 2) begin : g_bad
		$error("counts too small");
	end

	// ----------------------------------------
	// Pin synchronisers (straps, button, host inputs)
	// ----------------------------------------
	localparam int SW = 17; // Synchronised bits
	logic [SW-1:0] s1_q;    // First stage, read only by second
	logic [SW-1:0] s2_q;    // Second stage
	wire  [SW-1:0] pins = {host_hs_i, host_pin3_i, host_pin2_i, service_button_n,
	                       rate_select_bit0, rate_select_bit1, rate_select_bit2,
	                       auto_rate_strap, wiring_width_strap,
	                       network_enable_strap, host_location_strap,
	                       link_protocol_strap, role_strap_group};

	// Two flops on every asynchronous pin
	always_ff @(posedge clk) begin
		s1_q <= pins;
		s2_q <= s1_q;
	end

	// ----------------------------------------
	// Strap latch at reset release
	// ----------------------------------------
	logic       rst_seen_q; // Reset released and straps taken
	logic [8:0] strap_q;    // Latched straps

	// Straps taken on the first clock after reset release only
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rst_seen_q <= 1'b0;
			strap_q    <= {RATE_SEL_DEFAULT[0], RATE_SEL_DEFAULT[1],
			               RATE_SEL_DEFAULT[2], AUTO_OFF, WIRE_3,
			               NET_DISABLED, HOST_LOCAL, PROTO_ACK, ROLE_DCE};
		end else if (!rst_seen_q) begin
			rst_seen_q <= 1'b1;
			strap_q    <= s2_q[8:0];
		end
	end

	wire       dte      = strap_q[0] == ROLE_DTE;
	wire       auto_sel = strap_q[5] == AUTO_ON;
	wire [2:0] rsel     = {strap_q[6], strap_q[7], strap_q[8]};
	wire       hs_b     = s2_q[9];     // Button pin, low = pressed
	wire       p2_s     = s2_q[10];    // Pin 2 level
	wire       p3_s     = s2_q[11];    // Pin 3 level
	wire [4:0] hs_s     = s2_q[16:12]; // Handshake pin levels

	// ----------------------------------------
	// Rate selection
	// ----------------------------------------
	function automatic logic [DIV_W-1:0] div_of(input int unsigned r);
		div_of = DIV_W'(CLK_HZ / r);
	endfunction

	logic [DIV_W-1:0] fixed_div; // Divisor from rate straps
	always_comb begin
		unique case (rsel)
			3'h0: fixed_div = div_of(RATE_14400);
			3'h1: fixed_div = div_of(RATE_1200);
			3'h2: fixed_div = div_of(RATE_2400);
			3'h3: fixed_div = div_of(RATE_9600);
			3'h4: fixed_div = div_of(RATE_19200);
			3'h5: fixed_div = div_of(RATE_38400);
			3'h6: fixed_div = div_of(RATE_57600);
			3'h7: fixed_div = div_of(RATE_115200);
		endcase
	end

	// Autobaud only in 3-wire use, never with a modem
	wire auto_act = auto_sel && !dte && strap_q[4] == WIRE_3;
	// Detected rate replaces the straps while autobaud is on
	wire [DIV_W-1:0] div_d = auto_act ?
		(auto_rate_valid ? auto_rate_div : bit_div) : fixed_div;

	// ----------------------------------------
	// Host pin roles
	// ----------------------------------------
	wire hs_on = strap_q[4] == WIRE_8;
	// DCE: pin2 out (TXD), pin3 in; DTE swaps them
	wire rxd_d = dte ? p2_s : p3_s;
	// Outputs, 8-wire only (3-wire drives none): DCE drives DCD,DSR,CTS,RI; DTE drives DTR,RTS
	wire [5:0] hs_oe_d = !hs_on ? 6'h00 : (dte ? 6'h03 : 6'h3c);
	wire [5:0] hs_d = dte ? {4'h0, 1'b1, core_rts}
	                      : {1'b1, 1'b1, core_rts, 1'b0, 2'h0};

	// ----------------------------------------
	// Hold-off after reset
	// ----------------------------------------
	logic net_en_q; // Network traffic allowed
	always_ff @(posedge clk) begin
		if (!rst_n) net_en_q <= 1'b0;
		else if (!rst_seen_q) net_en_q <= s2_q[3] == NET_ENABLED;
		else if (holdoff_release_message) net_en_q <= 1'b1;
	end

	// ----------------------------------------
	// Service button: debounce, release detect, two-entry buffer
	// ----------------------------------------
	logic [$clog2(DEBOUNCE_CYCLES+1)-1:0] deb_q; // Settle counter
	logic btn_q;  // Debounced level, 1 = pressed
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			deb_q <= '0;
			btn_q <= 1'b0;
		end else if ((!hs_b) == btn_q) begin
			deb_q <= '0;
		end else if (deb_q == ($bits(deb_q))'(DEBOUNCE_CYCLES - 1)) begin
			deb_q <= '0;
			btn_q <= !hs_b;
		end else begin
			deb_q <= deb_q + 1'b1;
		end
	end
	wire release_ev = btn_q && hs_b &&
	                  deb_q == ($bits(deb_q))'(DEBOUNCE_CYCLES - 1);

	logic [1:0] cnt_q; // Messages buffered, 0..2
	wire push = release_ev && cnt_q != 2'h2;
	wire pop  = svc_ready && cnt_q != 2'h0;
	always_ff @(posedge clk) begin
		if (!rst_n) cnt_q <= 2'h0;
		else cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
	end

	// ----------------------------------------
	// Address store and nonvolatile write
	// ----------------------------------------
	logic nv_pend_q; // Write awaiting store
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			node_addr   <= NODE_DEFAULT;
			subnet_addr <= SUBNET_DEFAULT;
			nv_pend_q   <= 1'b0;
			nv_wr       <= 1'b0;
			nv_data     <= {NODE_DEFAULT, SUBNET_DEFAULT};
		end else begin
			if (addr_wr) begin
				node_addr   <= addr_node_in;
				subnet_addr <= addr_subnet_in;
				nv_data     <= {addr_node_in, addr_subnet_in};
			end
			nv_wr     <= nv_pend_q && nv_ready && !addr_wr;
			nv_pend_q <= addr_wr || (nv_pend_q && !nv_ready);
		end
	end

	// ----------------------------------------
	// Service indicator
	// ----------------------------------------
	logic cfgd_q; // Node configured
	logic [$clog2(BLINK_CYCLES)-1:0] blk_q; // Blink timer
	logic blink_q;
	led_mode_t mode;
	assign mode = hw_fault ? LED_ON : (cfgd_q ? LED_OFF : LED_BLINK);
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfgd_q  <= 1'b0;
			blk_q   <= '0;
			blink_q <= 1'b0;
		end else begin
			cfgd_q <= cfgd_q || cfg_done;
			if (blk_q == ($bits(blk_q))'(BLINK_CYCLES - 1)) begin
				blk_q   <= '0;
				blink_q <= !blink_q;
			end else begin
				blk_q <= blk_q + 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			host_pin2_o  <= 1'b1;
			host_pin2_oe <= 1'b0;
			host_pin3_o  <= 1'b1;
			host_pin3_oe <= 1'b0;
			host_hs_o    <= 6'h00;
			host_hs_oe   <= 6'h00;
			core_rxd     <= 1'b1;
			bit_div      <= div_of(RATE_9600);
			svc_valid    <= 1'b0;
			service_led  <= 1'b0;
		end else begin
			host_pin2_o  <= core_txd;
			host_pin2_oe <= !dte;
			host_pin3_o  <= core_txd;
			host_pin3_oe <= dte;
			host_hs_o    <= hs_d;
			host_hs_oe   <= hs_oe_d;
			core_rxd     <= rxd_d;
			bit_div      <= div_d;
			svc_valid    <= 2'(cnt_q + {1'b0, push} - {1'b0, pop}) != 2'h0;
			service_led  <= mode == LED_ON || (mode == LED_BLINK && blink_q);
		end
	end

	assign proto_buffered = strap_q[1] == PROTO_BUF;
	assign host_remote    = strap_q[2] == HOST_REMOTE;
	assign wire8          = hs_on;
	assign auto_rate_on   = auto_act;
	assign net_enable     = net_en_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_strap_hold: assert property (@(posedge clk) disable iff (!rst_n)
		rst_seen_q && $past(rst_seen_q) |-> $stable(strap_q))
		else $error("straps changed after capture");
	a_holdoff_release: assert property (@(posedge clk) disable iff (!rst_n)
		rst_seen_q && holdoff_release_message |=> net_enable)
		else $error("release message ignored");
	a_holdoff_keep: assert property (@(posedge clk) disable iff (!rst_n)
		net_enable |=> net_enable)
		else $error("network enable dropped");
	a_addr_take: assert property (@(posedge clk) disable iff (!rst_n)
		addr_wr |=> node_addr == $past(addr_node_in)
		         && subnet_addr == $past(addr_subnet_in))
		else $error("address not taken at once");
	a_nv_store: assert property (@(posedge clk) disable iff (!rst_n)
		addr_wr ##1 (!addr_wr && nv_ready) |=> nv_wr)
		else $error("address not stored");
	a_role_pins: assert property (@(posedge clk) disable iff (!rst_n)
		rst_seen_q |=> host_pin2_oe == !$past(dte) && host_pin3_oe == $past(dte))
		else $error("data pin roles wrong");
	a_rate_auto: assert property (@(posedge clk) disable iff (!rst_n)
		auto_act && auto_rate_valid |=> bit_div == $past(auto_rate_div))
		else $error("fixed rate used during autobaud");
	a_led_fault: assert property (@(posedge clk) disable iff (!rst_n)
		hw_fault |=> service_led)
		else $error("indicator dark on fault");
	a_svc_once: assert property (@(posedge clk) disable iff (!rst_n)
		cnt_q == 2'h0 && !release_ev |=> !svc_valid)
		else $error("message without release");

endmodule

`default_nettype wire

// File: tb/net_side_model.sv
// Purpose: Network and store side partner of the adapter core
// Assumes: Ready levels change at falling clock edges only
// Notes:   Stall holds both readies low so the buffer and store must wait
`timescale 1ns/1ps
`default_nettype none

module net_side_model (
	input  wire logic        clk,       // System clock
	input  wire logic        stall,     // Hold off both readies
	input  wire logic        svc_valid, // Message offered
	input  wire logic        nv_wr,     // Store write pulse
	input  wire logic [14:0] nv_data,   // Address being stored
	output logic             svc_ready, // Network takes a message
	output logic             nv_ready,  // Store can take a write
	output int               msg_count, // Messages taken so far
	output logic [14:0]      nv_last    // Last address stored
);
	// ----------------------------------------
	// Start idle, nothing taken
	// ----------------------------------------
	initial begin
		svc_ready = 1'b0;
		nv_ready  = 1'b0;
		msg_count = 0;
		nv_last   = 15'h0000;
	end

	// Readies follow stall, away from the sampling edge
	always @(negedge clk) begin
		svc_ready <= !stall;
		nv_ready  <= !stall;
	end

	// Take one message per handshake and keep what the store got
	always @(posedge clk) begin
		if (svc_valid && svc_ready) begin
			msg_count <= msg_count + 1;
		end
		if (nv_wr) begin
			nv_last <= nv_data;
		end
	end
endmodule

`default_nettype wire

// File: tb/serial_network_adapter_config_test.sv
// Purpose: Self-checking bench of the adapter configuration core
// Assumes: Short blink and debounce counts; inputs move at falling edges
// Notes:   Straps are packed as {role,proto,loc,net,wire,auto,rate[2:0]}
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module serial_network_adapter_config_test;
	import netadapt_pkg::*;

	// ----------------------------------------
	// Stimulus and observation
	// ----------------------------------------
	logic clk = 1'b0, rst_n = 1'b0, btn_n = 1'b1, p2 = 1'b0, p3 = 1'b0;
	logic txd = 1'b0, rts = 1'b0, av = 1'b0, rel = 1'b0, awr = 1'b0;
	logic cdone = 1'b0, fault = 1'b0, stall = 1'b0;
	logic [8:0] st = 9'h003;                 // Strap pins
	logic [4:0] hs_i = 5'h00;                // Handshake pin levels
	logic [DIV_W-1:0] adiv = 16'h0000;       // Detected divisor
	logic [6:0] anode = 7'h00;               // Node to write
	logic [7:0] asub = 8'h00;                // Subnet to write
	logic p2o, p2e, p3o, p3e, rxd, pbuf, rem, w8, aon, nen, sv, svr;
	logic nwr, nvr, led;
	logic [5:0] hso, hse;
	logic [DIV_W-1:0] div;
	logic [6:0] node;
	logic [7:0] sub;
	logic [14:0] nvd, nvl;
	int msgs, errors = 0, total_checks = 0;

	always #12.5 clk = ~clk;

	netadapt_cfg #(.BLINK_CYCLES(4), .DEBOUNCE_CYCLES(3)) DUT (
		.clk(clk), .rst_n(rst_n), .role_strap_group(st[8]),
		.link_protocol_strap(st[7]), .host_location_strap(st[6]),
		.network_enable_strap(st[5]), .wiring_width_strap(st[4]),
		.auto_rate_strap(st[3]), .rate_select_bit2(st[2]),
		.rate_select_bit1(st[1]), .rate_select_bit0(st[0]),
		.service_button_n(btn_n), .host_pin2_i(p2), .host_pin3_i(p3),
		.host_hs_i(hs_i), .core_txd(txd), .core_rts(rts),
		.auto_rate_valid(av), .auto_rate_div(adiv),
		.holdoff_release_message(rel), .addr_wr(awr),
		.addr_node_in(anode), .addr_subnet_in(asub), .cfg_done(cdone),
		.hw_fault(fault), .nv_ready(nvr), .svc_ready(svr),
		.host_pin2_o(p2o), .host_pin2_oe(p2e), .host_pin3_o(p3o),
		.host_pin3_oe(p3e), .host_hs_o(hso), .host_hs_oe(hse),
		.core_rxd(rxd), .proto_buffered(pbuf), .host_remote(rem),
		.wire8(w8), .auto_rate_on(aon), .bit_div(div), .net_enable(nen),
		.svc_valid(sv), .node_addr(node), .subnet_addr(sub), .nv_wr(nwr),
		.nv_data(nvd), .service_led(led));

	net_side_model far (.clk(clk), .stall(stall), .svc_valid(sv),
		.nv_wr(nwr), .nv_data(nvd), .svc_ready(svr), .nv_ready(nvr),
		.msg_count(msgs), .nv_last(nvl));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Reset for five cycles with the given straps, then let outputs settle
	task automatic do_reset(input logic [8:0] s);
		@(negedge clk);
		rst_n = 1'b0;
		st = s;
		tick(5);
		rst_n = 1'b1;
		tick(4);
	endtask

	// Divisor within one count of clock over rate
	function automatic logic near(input logic [DIV_W-1:0] d, input int r);
		int e;
		e = CLK_HZ / r;
		return (d >= e - 1) && (d <= e + 1);
	endfunction

	function automatic int rate_of(input logic [2:0] s);
		int t[8] = '{14400, 1200, 2400, 9600, 19200, 38400, 57600, 115200};
		return t[s];
	endfunction

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// All straps open: default role, link, host, hold-off, wiring, rate
	task automatic test_defaults();
		do_reset(9'h003);
		`CHK({pbuf, rem, w8, aon, nen}, 5'h00)
		`CHK(near(div, 9600), 1'b1)
		txd = 1'b1;
		p3 = 1'b1;
		tick(3);
		`CHK({p2e, p2o, p3e, rxd}, 4'hd)
		st = 9'h1f8;
		tick(4);
		`CHK({pbuf, rem, w8, p2e, p3e}, 5'h02)
		`CHK(near(div, 9600), 1'b1)
		$display("test_defaults done");
	endtask

	// Every rate code, autobaud off
	task automatic test_rates();
		for (int i = 0; i < 8; i++) begin
			do_reset({6'h00, i[2:0]});
			`CHK(near(div, rate_of(i[2:0])), 1'b1)
		end
		$display("test_rates done");
	endtask

	// Terminal role with full wiring swaps data and handshake directions
	task automatic test_roles();
		do_reset(9'h1d3);
		`CHK({pbuf, rem, w8, aon}, 4'he)
		txd = 1'b0;
		p2 = 1'b0;
		tick(3);
		`CHK({p3e, p3o, p2e, rxd}, 4'h8)
		`CHK(hse, 6'h03)
		`CHK(hso, 6'h02)
		txd = 1'b1;
		p2 = 1'b1;
		tick(3);
		`CHK({p3o, rxd}, 2'h3)
		do_reset(9'h013);
		`CHK({w8, hse}, 7'h7c)
		do_reset(9'h11b);
		`CHK(aon, 1'b0)
		$display("test_roles done");
	endtask

	// Autobaud adopts detected divisor, rate straps ignored
	task automatic test_auto();
		av = 1'b0;
		do_reset(9'h00f);
		`CHK(aon, 1'b1)
		adiv = 16'h0123;
		av = 1'b1;
		tick(3);
		`CHK(div, 16'h0123)
		av = 1'b0;
		$display("test_auto done");
	endtask

	// Hold-off until release message; enabled strap starts at once
	task automatic test_holdoff();
		do_reset(9'h003);
		tick(3);
		`CHK(nen, 1'b0)
		rel = 1'b1;
		tick(1);
		rel = 1'b0;
		`CHK(nen, 1'b1)
		do_reset(9'h023);
		`CHK(nen, 1'b1)
		$display("test_holdoff done");
	endtask

	// Back-to-back writes, store slow then ready
	task automatic test_address();
		int n;
		do_reset(9'h003);
		`CHK({node, sub}, {7'h7f, 8'h01})
		stall = 1'b1;
		tick(2);
		{awr, anode, asub} = {1'b1, 7'h05, 8'h22};
		tick(1);
		`CHK({node, sub}, {7'h05, 8'h22})
		{anode, asub} = {7'h11, 8'h33};
		tick(1);
		awr = 1'b0;
		`CHK({node, sub}, {7'h11, 8'h33})
		stall = 1'b0;
		for (n = 0; n < 20 && nvl !== 15'h1133; n++) tick(1);
		`CHK(nvl, {7'h11, 8'h33})
		$display("test_address done");
	endtask

	// Three presses while stalled: two held, third dropped
	task automatic test_service();
		int base;
		do_reset(9'h023);
		stall = 1'b1;
		base = msgs;
		repeat (3) begin
			btn_n = 1'b0;
			tick(8);
			btn_n = 1'b1;
			tick(8);
		end
		`CHK({sv, rxd}, 2'h3)
		stall = 1'b0;
		tick(10);
		`CHK(msgs - base, 2)
		`CHK(sv, 1'b0)
		$display("test_service done");
	endtask

	// Indicator blinks, then off when configured, then on with a fault
	task automatic test_led();
		int tg;
		logic prev;
		do_reset(9'h003);
		tg = 0;
		prev = led;
		repeat (30) begin
			tick(1);
			if (led !== prev) tg++;
			prev = led;
		end
		`CHK(tg >= 4, 1'b1)
		cdone = 1'b1;
		tick(1);
		cdone = 1'b0;
		tick(3);
		repeat (12) begin
			tick(1);
			`CHK(led, 1'b0)
		end
		fault = 1'b1;
		tick(3);
		repeat (12) begin
			tick(1);
			`CHK(led, 1'b1)
		end
		$display("test_led done");
	endtask

	// ----------------------------------------
	// Verdict
	// ----------------------------------------
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		test_defaults();
		test_rates();
		test_roles();
		test_auto();
		test_holdoff();
		test_address();
		test_service();
		test_led();
		complete_run();
	end
endmodule

`default_nettype wire
